// File: drs_consts.vh
// constants for the ramp sweep control block
// assumes plain verilog-2005, included by bare name
// Operation
// - no-dwell on: output returns to start value when sweep completes.
// - no-dwell off: output holds final value after sweep completes.
// - edge trigger: profile pin edge starts one single sweep.
// - state trigger: sweep restarts repeatedly while profile pin 0 high.
// - sweep modes up, down, bidirectional, none; none holds ramp reset.
// - dc output forces dac code full scale, suppresses synthesizer output.
// - auto-clear zeroes accumulator one cycle on each update strobe.
// - clear setting holds accumulator asynchronously reset while set.
// - load-on-update aborts step timer on update, reloads step rate.
// - modulus mode: fractional modulus from base, limit and step words.
// - register data arrives as plain ports; the serial data pin is never driven.
// - registers are at most eight bytes wide.
// - serial clock rises are only counted while chip select low; state machines run on clk.
// - ramp starts at start point, steps by step size per interval.
// - profile from three-bit control field or pins, pins serial mode only.
`ifndef DRS_CONSTS_VH
`define DRS_CONSTS_VH
`define DRS_AW 32
`define DRS_DACW 10
`define DRS_RATEW 16
`define DRS_SW_NONE 2'h0
`define DRS_SW_UP 2'h1
`define DRS_SW_DOWN 2'h2
`define DRS_SW_BIDIR 2'h3
`define DRS_PROF_FIELD_HI 22
`define DRS_PROF_FIELD_LO 20
`define DRS_DAC_FULL 10'h3ff
`endif

// File: drs_sync.v
// two-flop synchroniser for a bus of pin inputs
// assumes inputs asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module drs_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;
    // =====================================
    // first stage read only by second stage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: drs_ramp_ctrl.v
// digital ramp generator control: sweep, triggering, clears, modulus
// assumes host drives profile pins, update strobe and serial clock
// asynchronously; register contents arrive as plain ports
`timescale 1ns/1ps
`default_nettype none
`include "drs_consts.vh"
module drs_ramp_ctrl (
    input wire clk,
    input wire rst_n,
    input wire profile_select_bit0,
    input wire profile_select_bit1,
    input wire profile_select_bit2,
    input wire io_update,
    input wire serial_clk,
    input wire chip_select_n,
    input wire serial_data_io_in,
    output reg serial_data_io_out,
    output reg serial_data_io_oe,
    input wire [2:0] profile_field,
    input wire use_profile_pins,
    input wire serial_mode,
    input wire no_dwell,
    input wire state_trigger,
    input wire [1:0] sweep_type,
    input wire dc_output,
    input wire auto_clear,
    input wire clear_accum,
    input wire load_on_update,
    input wire [`DRS_RATEW-1:0] step_rate_value,
    input wire [`DRS_AW-1:0] start_word,
    input wire [`DRS_AW-1:0] end_word,
    input wire [`DRS_AW-1:0] step_word,
    input wire mod_enable,
    input wire [`DRS_AW-1:0] base_word,
    input wire [`DRS_AW-1:0] mod_limit,
    input wire [`DRS_AW-1:0] mod_step,
    output reg [`DRS_AW-1:0] tuning_word,
    output reg [`DRS_DACW-1:0] dac_code,
    output reg dds_enable,
    output reg [2:0] active_profile,
    output reg sweep_done,
    output reg [7:0] sclk_edges
);
    // =====================================
    // input synchronisers
    wire [2:0] prof_s;
    wire upd_s;
    wire sclk_s;
    wire csn_s;
    drs_sync #(.W(6)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({profile_select_bit2, profile_select_bit1, profile_select_bit0,
            io_update, serial_clk, chip_select_n}),
        .q({prof_s, upd_s, sclk_s, csn_s})
    );

    // =====================================
    // edge detection on synchronised levels
    reg upd_d_r;
    reg sclk_d_r;
    reg [2:0] prof_d_r;
    wire upd_rise = upd_s & ~upd_d_r;
    wire sclk_rise = sclk_s & ~sclk_d_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upd_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
            prof_d_r <= 3'h0;
        end else begin
            upd_d_r <= upd_s;
            sclk_d_r <= sclk_s;
            prof_d_r <= prof_s;
        end
    end

    // pick the active profile from the pins or the control field
    function [2:0] pick_profile;
        input pins_ok;
        input [2:0] pins;
        input [2:0] field;
        begin
            pick_profile = pins_ok ? pins : field;
        end
    endfunction

    wire pins_ok = use_profile_pins & serial_mode;
    wire [2:0] prof_now = pick_profile(pins_ok, prof_s, profile_field);
    wire trig_lvl = prof_s[0];
    wire trig_edge = prof_s[0] & ~prof_d_r[0];

    // =====================================
    // serial clock activity: rises counted while chip select low, data pin never driven
    // here since register access is modelled by plain ports
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_edges <= 8'h00;
            serial_data_io_out <= 1'b0;
            serial_data_io_oe <= 1'b0;
        end else begin
            if (!csn_s && sclk_rise) begin
                sclk_edges <= sclk_edges + 8'h01;
            end
            serial_data_io_out <= 1'b0;
            serial_data_io_oe <= 1'b0;
        end
    end

    // =====================================
    // step-rate timer
    reg [`DRS_RATEW-1:0] timer_r;
    wire step_tick = (timer_r == {`DRS_RATEW{1'b0}});
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_r <= {`DRS_RATEW{1'b0}};
        end else if (load_on_update && upd_rise) begin
            timer_r <= step_rate_value;
        end else if (step_tick) begin
            timer_r <= step_rate_value;
        end else begin
            timer_r <= timer_r - {{(`DRS_RATEW-1){1'b0}}, 1'b1};
        end
    end

    // =====================================
    // sweep state machine
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_DONE = 2'h2;
    reg [1:0] st_r;
    reg dir_dn_r;
    reg [`DRS_AW-1:0] acc_r;
    wire none_sw = (sweep_type == `DRS_SW_NONE);
    wire [`DRS_AW:0] up_sum = {1'b0, acc_r} + {1'b0, step_word};
    wire at_end = (up_sum >= {1'b0, end_word});
    wire at_start = (acc_r <= start_word + step_word);
    wire start_req = state_trigger ? trig_lvl : trig_edge;
    // async clear holds the accumulator; a glitch-free static level
    wire acc_rst_n = rst_n & ~clear_accum;

    always @(posedge clk or negedge acc_rst_n) begin
        if (!acc_rst_n) begin
            acc_r <= {`DRS_AW{1'b0}};
            st_r <= ST_IDLE;
            dir_dn_r <= 1'b0;
        end else if (none_sw) begin
            acc_r <= {`DRS_AW{1'b0}};
            st_r <= ST_IDLE;
            dir_dn_r <= 1'b0;
        end else if (auto_clear && upd_rise) begin
            acc_r <= {`DRS_AW{1'b0}};
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (start_req) begin
                        acc_r <= (sweep_type == `DRS_SW_DOWN) ? end_word
                                 : start_word;
                        dir_dn_r <= (sweep_type == `DRS_SW_DOWN);
                        st_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (step_tick && !dir_dn_r) begin
                        if (at_end) begin
                            acc_r <= end_word;
                            if (sweep_type == `DRS_SW_BIDIR) begin
                                dir_dn_r <= 1'b1;
                            end else begin
                                st_r <= ST_DONE;
                            end
                        end else begin
                            acc_r <= up_sum[`DRS_AW-1:0];
                        end
                    end else if (step_tick) begin
                        if (at_start) begin
                            acc_r <= start_word;
                            st_r <= ST_DONE;
                        end else begin
                            acc_r <= acc_r - step_word;
                        end
                    end
                end
                ST_DONE: begin
                    if (no_dwell) begin
                        acc_r <= (sweep_type == `DRS_SW_DOWN) ? end_word
                                 : start_word;
                    end
                    // without no-dwell acc_r keeps the final value
                    if (state_trigger && trig_lvl) begin
                        st_r <= ST_IDLE;
                    end else if (!trig_lvl) begin
                        st_r <= ST_IDLE; // rearm single sweep on low
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // =====================================
    // programmable modulus: fractional accumulator of limit/step
    reg [`DRS_AW-1:0] frac_r;
    reg carry_r;
    wire [`DRS_AW:0] frac_sum = {1'b0, frac_r} + {1'b0, mod_step};
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frac_r <= {`DRS_AW{1'b0}};
            carry_r <= 1'b0;
        end else if (!mod_enable) begin
            frac_r <= {`DRS_AW{1'b0}};
            carry_r <= 1'b0;
        end else if (frac_sum >= {1'b0, mod_limit}) begin
            frac_r <= frac_sum[`DRS_AW-1:0] - mod_limit;
            carry_r <= 1'b1;
        end else begin
            frac_r <= frac_sum[`DRS_AW-1:0];
            carry_r <= 1'b0;
        end
    end

    // =====================================
    // registered outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tuning_word <= {`DRS_AW{1'b0}};
            dac_code <= {`DRS_DACW{1'b0}};
            dds_enable <= 1'b0;
            active_profile <= 3'h0;
            sweep_done <= 1'b0;
        end else begin
            if (mod_enable) begin
                tuning_word <= base_word + {{(`DRS_AW-1){1'b0}}, carry_r};
            end else begin
                tuning_word <= acc_r;
            end
            dac_code <= dc_output ? `DRS_DAC_FULL
                        : acc_r[`DRS_AW-1:`DRS_AW-`DRS_DACW];
            dds_enable <= ~dc_output;
            active_profile <= prof_now;
            sweep_done <= (st_r == ST_DONE);
        end
    end
endmodule
`default_nettype wire

// File: drs_ramp_chk_assertions.sv
// checker for the ramp sweep control block, bound to drs_ramp_ctrl
// assumes config ports change only while the checked output is quiet
`timescale 1ns/1ps
`default_nettype none
`include "drs_consts.vh"
module drs_ramp_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic io_update,
    input wire logic [2:0] profile_field,
    input wire logic use_profile_pins,
    input wire logic serial_mode,
    input wire logic no_dwell,
    input wire logic [1:0] sweep_type,
    input wire logic dc_output,
    input wire logic auto_clear,
    input wire logic clear_accum,
    input wire logic mod_enable,
    input wire logic [`DRS_AW-1:0] start_word,
    input wire logic [`DRS_AW-1:0] end_word,
    input wire logic [`DRS_AW-1:0] tuning_word,
    input wire logic [`DRS_DACW-1:0] dac_code,
    input wire logic dds_enable,
    input wire logic [2:0] active_profile,
    input wire logic sweep_done,
    input wire logic serial_data_io_oe
);
    // ====
    // warm-up: outputs may still be zero on the first edge after reset
    logic [1:0] up_r;
    wire up = (up_r == 2'h3);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) up_r <= 2'h0;
        else if (!up) up_r <= up_r + 2'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_dc_full: assert property (up && dc_output && $past(dc_output)
        |-> dac_code == `DRS_DAC_FULL && !dds_enable)
        else $error("dc output not at full scale");
    chk_clear_hold: assert property (
        (up && clear_accum && !mod_enable)[*3] |-> tuning_word == 32'h0)
        else $error("accumulator not held clear");
    chk_none_zero: assert property (
        (up && sweep_type == `DRS_SW_NONE && !mod_enable && !clear_accum)[*3]
        |-> tuning_word == 32'h0) else $error("no-sweep output not zero");
    chk_auto_clear: assert property (up && auto_clear && !mod_enable
        && $rose(io_update) |-> ##[1:8] tuning_word == 32'h0)
        else $error("auto clear missed");
    chk_done_end: assert property ($rose(sweep_done) && !no_dwell
        && sweep_type == `DRS_SW_UP && !mod_enable
        |-> ##[0:2] tuning_word == end_word) else $error("no hold at end");
    chk_no_dwell: assert property ($rose(sweep_done) && no_dwell
        && sweep_type == `DRS_SW_UP && !mod_enable
        |-> ##[0:4] tuning_word == start_word) else $error("no return");
    chk_profile_sel: assert property (
        (up && !(use_profile_pins && serial_mode) && $stable(profile_field))[*3]
        |-> active_profile == profile_field) else $error("profile mismatch");
    chk_sdio_idle: assert property (up |-> !serial_data_io_oe)
        else $error("data pin driven");
endmodule
bind drs_ramp_ctrl drs_ramp_chk u_drs_ramp_chk (.*);
`default_nettype wire

// File: drs_host_model.sv
// host model: one serial frame of eight bits per rise of go
// assumes the device only listens on the data pin
`timescale 1ns/1ps
`default_nettype none
module drs_host_model (
    input wire logic go,
    input wire logic [7:0] word,
    output logic serial_clk,
    output logic chip_select_n,
    output logic data_out
);
    integer k;
    // ====
    // link clock idles low outside frames, 800 ns period inside
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        data_out = 1'b0;
    end
    always @(posedge go) begin
        chip_select_n = 1'b0;
        for (k = 7; k >= 0; k--) begin
            data_out = word[k];
            #400 serial_clk = 1'b1;
            #400 serial_clk = 1'b0;
        end
        #400 chip_select_n = 1'b1;
        data_out = ~data_out; // driven inverted: last bit not left standing
    end
endmodule
`default_nettype wire

// File: drs_ramp_ctrl_tb.sv
// self-checking bench for drs_ramp_ctrl with a host model
// assumes inputs change at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module drs_ramp_ctrl_tb;
    logic clk = 0, rst_n = 0, p0 = 0, p1 = 0, p2 = 0, upd = 0, go = 0;
    logic pins = 0, smode = 0, nd = 0, st = 0, dc = 0, ac = 0, clr = 0;
    logic lou = 0, mod_en = 0;
    logic [1:0] sw = 0;
    logic [2:0] pf = 0;
    logic [7:0] e0;
    logic [31:0] base = 0, mlim = 0, mstep = 0, hw = 0, em, r0;
    logic [31:0] seed = 32'hf0124053;
    logic [31:0] expq[$];
    wire sclk, cs_n, hd, sdo, soe, done, dds_en;
    wire [31:0] tw;
    wire [9:0] dac;
    wire [2:0] prof;
    wire [7:0] edges;
    wire sdio = soe ? sdo : hd; // device never drives, host line wins
    int fails = 0, total_checks = 0, rises = 0, i;
    drs_host_model u_drs_host_model (.go(go), .word(hw[7:0]),
        .serial_clk(sclk), .chip_select_n(cs_n), .data_out(hd));
    drs_ramp_ctrl u_drs_ramp_ctrl (.clk(clk), .rst_n(rst_n),
        .profile_select_bit0(p0), .profile_select_bit1(p1),
        .profile_select_bit2(p2), .io_update(upd), .serial_clk(sclk),
        .chip_select_n(cs_n), .serial_data_io_in(sdio),
        .serial_data_io_out(sdo), .serial_data_io_oe(soe),
        .profile_field(pf), .use_profile_pins(pins), .serial_mode(smode),
        .no_dwell(nd), .state_trigger(st), .sweep_type(sw), .dc_output(dc),
        .auto_clear(ac), .clear_accum(clr), .load_on_update(lou),
        .step_rate_value(16'h0002), .start_word(32'h100),
        .end_word(32'h1f0), .step_word(32'h40), .mod_enable(mod_en),
        .base_word(base), .mod_limit(mlim), .mod_step(mstep),
        .tuning_word(tw), .dac_code(dac), .dds_enable(dds_en),
        .active_profile(prof), .sweep_done(done), .sclk_edges(edges));
    function logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task end_of_test;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ====
    // one edge-triggered sweep; pin held well past the end
    task run(input logic [1:0] t, input logic n, input logic [31:0] e);
        sw = t;
        nd = n;
        expq.push_back(e);
        p0 = 1'b1;
        tick(6);
        for (i = 0; i < 400 && done !== 1'b1; i++) tick(1);
        if (done !== 1'b1) begin fails++; end_of_test; end
        tick(40);
        p0 = 1'b0;
        tick(12);
    endtask
    initial forever #50 clk = ~clk;
    // ====
    // result watcher: settled output compared against oldest note
    always @(posedge done) begin
        rises++;
        if (expq.size() > 0) begin
            em = expq.pop_front();
            tick(6);
            `CHK(tw, em)
        end
    end
    initial begin
        tick(20);
        rst_n = 1'b1;
        tick(4);
        e0 = edges;
        seed = xs(seed);
        hw = seed;
        go = 1'b1;
        tick(2);
        for (i = 0; i < 200 && cs_n !== 1'b1; i++) tick(1);
        if (cs_n !== 1'b1) begin fails++; end_of_test; end
        go = 1'b0;
        tick(4);
        `CHK(edges, e0 + 8'h08)
        for (int j = 0; j < 4; j++) begin
            seed = xs(seed);
            {pins, smode} = j[1:0];
            {p2, p1} = seed[1:0];
            pf = seed[6:4];
            tick(8);
            `CHK(prof, (pins && smode) ? {p2, p1, 1'b0} : pf)
        end
        p0 = 1'b1;
        tick(10);
        `CHK(tw, 32'h0)
        p0 = 1'b0;
        tick(4);
        run(2'h1, 1'b0, 32'h1f0);
        `CHK(rises, 1)
        run(2'h1, 1'b1, 32'h100);
        run(2'h2, 1'b0, 32'h100);
        run(2'h3, 1'b0, 32'h100);
        dc = 1'b1;
        tick(4);
        `CHK({dac, dds_en}, 11'h7fe)
        dc = 1'b0;
        ac = 1'b1;
        lou = 1'b1;
        upd = 1'b1;
        tick(10);
        `CHK(tw, 32'h0)
        {ac, upd} = 2'h0;
        // refill the accumulator so the static clear has work to do
        run(2'h1, 1'b0, 32'h1f0);
        clr = 1'b1;
        tick(5);
        `CHK(tw, 32'h0)
        clr = 1'b0;
        {st, sw, nd} = 4'hb;
        r0 = rises;
        p0 = 1'b1;
        tick(150);
        p0 = 1'b0;
        `CHK(rises - r0 >= 2, 1'b1)
        {st, sw} = 3'h0;
        tick(20);
        `CHK(tw, 32'h0)
        seed = xs(seed);
        base = seed;
        mlim = xs(seed);
        mod_en = 1'b1;
        tick(8);
        `CHK(tw, base)
        // limit 3, step 1: one carry every third cycle
        {mlim, mstep} = {32'h3, 32'h1};
        tick(8);
        r0 = 0;
        for (i = 0; i < 30; i++) begin
            tick(1);
            r0 = r0 + (tw == base + 32'h1);
        end
        `CHK(r0, 32'ha)
        end_of_test;
    end
endmodule
`default_nettype wire
